// File: core/pbcs_core.sv
// Processor bus cycle signals: reset out, direction, size, acknowledge,
// and transaction code, in both master and slave roles.
// Assumes the bus partner runs on this same clock; pins still pass two
// flops, pin-level tristate is resolved outside from the enables.
// Notes on behaviour
// R1 - Local reset clears local-side logic only
// R2 - Reset out on PCI reset or soft reset
// R3 - Direction high read, low write, address timing
// R4 - Drive direction only as master, else input
// R5 - Byte lanes from size, address, port width
// R6 - Size both bits set means line burst
// R7 - Drive transaction code only as master
// R8 - Slave samples code at qualified start edge
// R9 - Master code comes from target image field
// R10 - Size codes: word, byte, half, line/reserved
// R11 - Start strobe lasts exactly one clock
// R12 - Slave acks, negates before release; retry both
// R13 - Partner logic synchronous to local clock
// R14 - Reset out held until both sources idle

`timescale 1ns/1ps
`default_nettype none

module pbcs_core #(
	parameter int TC_W   = pbcs_pkg::TC_W,
	parameter int LANE_W = pbcs_pkg::LANE_W
) (
	// Clock, enable, resets
	input  wire logic              clock,
	input  wire logic              rst_b,
	input  wire logic              clk_en,
	input  wire logic              local_reset_in_n,
	input  wire logic              pci_reset_n,
	input  wire logic              soft_reset,
	output var  logic              local_reset_out_n_oe,
	// Master request from bridge core
	input  wire logic              mst_req,
	input  wire logic              mst_read,
	input  wire logic [1:0]        mst_size,
	input  wire logic [TC_W-1:0]   image_tc,
	output var  logic              mst_done,
	output var  logic              mst_err,
	// Master pins
	output var  logic              transfer_start_n_o,
	output var  logic              transfer_start_n_oe,
	output var  logic              rw_o,
	output var  logic              rw_oe,
	output var  logic [1:0]        transfer_size_o,
	output var  logic              transfer_size_oe,
	output var  logic [TC_W-1:0]   transaction_code_bus_o,
	output var  logic              transaction_code_bus_oe,
	input  wire logic              transfer_ack_n_i,
	input  wire logic              transfer_error_ack_n_i,
	// Slave pins and lane inputs
	input  wire logic              slv_sel,
	input  wire logic              transfer_start_n_i,
	input  wire logic              rw_i,
	input  wire logic [1:0]        transfer_size_i,
	input  wire logic [TC_W-1:0]   transaction_code_bus_i,
	input  wire logic [1:0]        addr_lo,
	input  wire logic [1:0]        port_width,
	output var  logic              slave_ack_n_o,
	output var  logic              slave_ack_n_oe,
	output var  logic              transfer_error_ack_n_o,
	output var  logic              transfer_error_ack_n_oe,
	// Slave side to bridge core
	input  wire logic              slv_ready,
	input  wire logic              slv_retry,
	output var  logic              slv_start,
	output var  logic              slv_read,
	output var  logic              slv_burst,
	output var  logic [TC_W-1:0]   slv_tc,
	output var  logic [LANE_W-1:0] slv_lanes
);
	// ---------------------------------------------------------------
	// Byte lane decode
	// ---------------------------------------------------------------
	function automatic logic [LANE_W-1:0] lanes_f(
		input logic [1:0] siz, a, pw
	);
		logic [LANE_W-1:0] m;
		m = pbcs_pkg::LANES_NONE;
		case (siz) // R5 R10
			pbcs_pkg::SIZE_BYTE: m = LANE_W'(1) << a;
			pbcs_pkg::SIZE_HALF: m = a[1] ? LANE_W'(12) : LANE_W'(3);
			default:             m = pbcs_pkg::LANES_ALL; // R6
		endcase
		// Narrow ports carry everything on their upper lanes
		if (pw == pbcs_pkg::PORT_16)
			m = a[1] ? (m & LANE_W'(12)) : LANE_W'(12);
		else if (pw == pbcs_pkg::PORT_8)
			m = LANE_W'(8);
		return m;
	endfunction : lanes_f

	// ---------------------------------------------------------------
	// Synchronisers for pins
	// ---------------------------------------------------------------
	logic lrst_s, prst_s, ts_s, ta_s, tea_s;
	pbcs_sync u_s_lrst (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
		.d(local_reset_in_n), .q(lrst_s));
	pbcs_sync u_s_prst (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
		.d(pci_reset_n), .q(prst_s));
	pbcs_sync u_s_ts (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
		.d(transfer_start_n_i), .q(ts_s));
	pbcs_sync u_s_ta (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
		.d(transfer_ack_n_i), .q(ta_s));
	pbcs_sync u_s_tea (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
		.d(transfer_error_ack_n_i), .q(tea_s));
	// Qualifier bits arrive with the start strobe; delay them to match
	logic [1:0]      rw_d_reg, siz_d0_reg, siz_d1_reg;
	logic [TC_W-1:0] tc_d0_reg, tc_d1_reg;
	logic [1:0]      a_d0_reg, a_d1_reg, sel_d_reg;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rw_d_reg   <= 2'h0;
			siz_d0_reg <= pbcs_pkg::SIZE_WORD;
			siz_d1_reg <= pbcs_pkg::SIZE_WORD;
			tc_d0_reg  <= pbcs_pkg::TC_RESET;
			tc_d1_reg  <= pbcs_pkg::TC_RESET;
			a_d0_reg   <= 2'h0;
			a_d1_reg   <= 2'h0;
			sel_d_reg  <= 2'h0;
		end else if (clk_en) begin
			rw_d_reg   <= {rw_d_reg[0], rw_i};
			siz_d0_reg <= transfer_size_i;
			siz_d1_reg <= siz_d0_reg;
			tc_d0_reg  <= transaction_code_bus_i;
			tc_d1_reg  <= tc_d0_reg;
			a_d0_reg   <= addr_lo;
			a_d1_reg   <= a_d0_reg;
			sel_d_reg  <= {sel_d_reg[0], slv_sel};
		end
	end
	// Local-side reset: clocked entry and release via synchroniser.
	// PCI configuration state lives elsewhere and never sees this.
	logic lrst_n;
	assign lrst_n = rst_b & lrst_s; // R1

	// ---------------------------------------------------------------
	// Reset output
	// ---------------------------------------------------------------
	logic rsto_next;
	always_comb begin
		rsto_next = local_reset_out_n_oe;
		if (clk_en)
			rsto_next = !prst_s || soft_reset; // R2 R14
	end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			local_reset_out_n_oe <= 1'b1;
		else
			local_reset_out_n_oe <= rsto_next;
	end

	// ---------------------------------------------------------------
	// Master cycle
	// ---------------------------------------------------------------
	pbcs_pkg::pbcs_mstate_t m_reg, m_next;
	logic            ts_next, own_next, rw_next, done_next, err_next;
	logic [1:0]      siz_next;
	logic [TC_W-1:0] tc_next;
	always_comb begin
		m_next    = m_reg;
		ts_next   = 1'b1;
		own_next  = transfer_size_oe;
		rw_next   = rw_o;
		siz_next  = transfer_size_o;
		tc_next   = transaction_code_bus_o;
		done_next = 1'b0;
		err_next  = 1'b0;
		case (m_reg)
			pbcs_pkg::M_IDLE: begin
				// Line code is reserved as master; downgrade to word
				if (mst_req) begin
					m_next   = pbcs_pkg::M_START;
					ts_next  = 1'b0; // R11
					own_next = 1'b1; // R4 R7
					rw_next  = mst_read; // R3
					siz_next = (mst_size == pbcs_pkg::SIZE_LINE) ?
						pbcs_pkg::SIZE_WORD : mst_size; // R10
					tc_next  = image_tc; // R9
				end
			end
			pbcs_pkg::M_START: m_next = pbcs_pkg::M_WAIT;
			pbcs_pkg::M_WAIT: begin
				if (!ta_s || !tea_s) begin
					m_next    = pbcs_pkg::M_IDLE;
					own_next  = 1'b0; // R4 R7
					done_next = 1'b1;
					err_next  = !tea_s;
				end
			end
			default: m_next = pbcs_pkg::M_IDLE;
		endcase
	end
	// Enable gates the whole bank so pins and pulses freeze together
	always_ff @(posedge clock or negedge lrst_n) begin
		if (!lrst_n) begin
			m_reg                   <= pbcs_pkg::M_IDLE;
			transfer_start_n_o      <= 1'b1;
			transfer_start_n_oe     <= 1'b0;
			rw_o                    <= 1'b1;
			rw_oe                   <= 1'b0;
			transfer_size_o         <= pbcs_pkg::SIZE_WORD;
			transfer_size_oe        <= 1'b0;
			transaction_code_bus_o  <= pbcs_pkg::TC_RESET;
			transaction_code_bus_oe <= 1'b0;
			mst_done                <= 1'b0;
			mst_err                 <= 1'b0;
		end else if (clk_en) begin
			m_reg                   <= m_next;
			transfer_start_n_o      <= ts_next;
			transfer_start_n_oe     <= own_next;
			rw_o                    <= rw_next;
			rw_oe                   <= own_next;
			transfer_size_o         <= siz_next;
			transfer_size_oe        <= own_next;
			transaction_code_bus_o  <= tc_next;
			transaction_code_bus_oe <= own_next;
			mst_done                <= done_next;
			mst_err                 <= err_next;
		end
	end

	// ---------------------------------------------------------------
	// Slave cycle
	// ---------------------------------------------------------------
	pbcs_pkg::pbcs_sstate_t s_reg, s_next;
	logic            st_next, ack_next, tea_next, soe_next;
	logic            sr_next, sb_next;
	logic [TC_W-1:0] stc_next;
	logic [LANE_W-1:0] ln_next;
	always_comb begin
		s_next   = s_reg;
		st_next  = 1'b0;
		ack_next = 1'b1;
		tea_next = 1'b1;
		soe_next = slave_ack_n_oe;
		sr_next  = slv_read;
		sb_next  = slv_burst;
		stc_next = slv_tc;
		ln_next  = slv_lanes;
		case (s_reg)
			pbcs_pkg::S_IDLE: begin
				soe_next = 1'b0;
				if (!ts_s && sel_d_reg[1] && !transfer_start_n_oe) begin
					s_next   = pbcs_pkg::S_BUSY;
					st_next  = 1'b1;
					sr_next  = rw_d_reg[1]; // R3 R4
					sb_next  = siz_d1_reg == pbcs_pkg::SIZE_LINE; // R6
					stc_next = tc_d1_reg; // R8
					ln_next  = lanes_f(siz_d1_reg, a_d1_reg,
						port_width); // R5
				end
			end
			pbcs_pkg::S_BUSY: begin
				if (slv_ready || slv_retry) begin
					s_next   = pbcs_pkg::S_ACK;
					ack_next = 1'b0; // R12
					tea_next = !slv_retry; // R12
					soe_next = 1'b1;
				end
			end
			pbcs_pkg::S_ACK: begin
				// Drive high one cycle before letting go of the line
				s_next   = pbcs_pkg::S_IDLE; // R12
				soe_next = 1'b1;
			end
			default: s_next = pbcs_pkg::S_IDLE;
		endcase
	end
	always_ff @(posedge clock or negedge lrst_n) begin
		if (!lrst_n) begin
			s_reg                   <= pbcs_pkg::S_IDLE;
			slv_start               <= 1'b0;
			slave_ack_n_o           <= 1'b1;
			slave_ack_n_oe          <= 1'b0;
			transfer_error_ack_n_o  <= 1'b1;
			transfer_error_ack_n_oe <= 1'b0;
			slv_read                <= 1'b0;
			slv_burst               <= 1'b0;
			slv_tc                  <= pbcs_pkg::TC_RESET;
			slv_lanes               <= pbcs_pkg::LANES_NONE;
		end else if (clk_en) begin
			s_reg                   <= s_next;
			slv_start               <= st_next;
			slave_ack_n_o           <= ack_next;
			slave_ack_n_oe          <= soe_next;
			transfer_error_ack_n_o  <= tea_next;
			transfer_error_ack_n_oe <= soe_next;
			slv_read                <= sr_next;
			slv_burst               <= sb_next;
			slv_tc                  <= stc_next;
			slv_lanes               <= ln_next;
		end
	end
endmodule : pbcs_core

`default_nettype wire

// File: common/pbcs_pkg.sv
// Package for the processor bus cycle signalling block.
// Assumes a single local bus clock; no software-visible registers.

package pbcs_pkg;

	// ---------------------------------------------------------------
	// Transfer size encoding
	// ---------------------------------------------------------------
	localparam logic [1:0] SIZE_WORD = 2'h0;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_HALF = 2'h2;
	localparam logic [1:0] SIZE_LINE = 2'h3;

	// ---------------------------------------------------------------
	// Widths and reset values
	// ---------------------------------------------------------------
	localparam int          TC_W        = 4;
	localparam int          LANE_W      = 4;
	localparam logic [3:0]  TC_RESET    = 4'h0;
	localparam logic [3:0]  LANES_NONE  = 4'h0;
	localparam logic [3:0]  LANES_ALL   = 4'hf;
	localparam logic [1:0]  PORT_32     = 2'h0;
	localparam logic [1:0]  PORT_16     = 2'h1;
	localparam logic [1:0]  PORT_8      = 2'h2;

	// ---------------------------------------------------------------
	// Master cycle states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		M_IDLE  = 3'b001,
		M_START = 3'b010,
		M_WAIT  = 3'b100
	} pbcs_mstate_t;

	// ---------------------------------------------------------------
	// Slave cycle states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_BUSY = 3'b010,
		S_ACK  = 3'b100
	} pbcs_sstate_t;

endpackage : pbcs_pkg

// File: core/pbcs_sync.sv
// Two-flop synchroniser, one bit wide, for pins entering the clock domain.
// Assumes the clock enable freezes it like all other state.

`timescale 1ns/1ps
`default_nettype none

module pbcs_sync (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic clk_en,
	// Data
	input  wire logic d,
	output var  logic q
);

	logic meta_reg;
	logic meta_next;
	logic q_next;

	always_comb begin
		meta_next = clk_en ? d : meta_reg;
		q_next    = clk_en ? meta_reg : q;
	end

	// Reset value high: the pins we carry are idle high
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= 1'b1;
			q        <= 1'b1;
		end else begin
			meta_reg <= meta_next;
			q        <= q_next;
		end
	end

endmodule : pbcs_sync

`default_nettype wire

// File: bench/pbcs_core_assertions.sv
// Checker for pbcs_core, bound from the bench top; sees only its ports.
// Judges nothing while reset is asserted or clk_en holds the block.
`timescale 1ns/1ps
`default_nettype none
module pbcs_core_assertions #(
	parameter int TC_W = 4
) (
	// Clock and resets
	input wire logic            clock,
	input wire logic            rst_b,
	input wire logic            clk_en,
	input wire logic            local_reset_in_n,
	input wire logic            pci_reset_n,
	input wire logic            soft_reset,
	input wire logic            local_reset_out_n_oe,
	// Master side
	input wire logic [1:0]      mst_size,
	input wire logic [TC_W-1:0] image_tc,
	input wire logic            transfer_start_n_o,
	input wire logic            rw_oe,
	input wire logic [1:0]      transfer_size_o,
	input wire logic [TC_W-1:0] transaction_code_bus_o,
	input wire logic            transaction_code_bus_oe,
	// Slave side
	input wire logic [TC_W-1:0] transaction_code_bus_i,
	input wire logic            slave_ack_n_o,
	input wire logic            slave_ack_n_oe,
	input wire logic            transfer_error_ack_n_o,
	input wire logic            slv_start,
	input wire logic [TC_W-1:0] slv_tc
);
	// --------------------------------
	// Relations at the pins
	// --------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b || !clk_en);
	// Four cycles cover the three-edge sync path of the PCI reset; soft reset is not synchronised
	a_rst_out_pci: assert property (!pci_reset_n [*4] |-> local_reset_out_n_oe)
		else $error("reset out idle in pci reset");
	a_rst_out_soft: assert property (soft_reset [*4] |-> local_reset_out_n_oe)
		else $error("reset out idle in soft reset");
	a_rst_out_free: assert property ((pci_reset_n && !soft_reset) [*4] |-> !local_reset_out_n_oe)
		else $error("reset out stuck");
	a_local_rst_idle: assert property (!local_reset_in_n [*4] |-> !rw_oe && !slave_ack_n_oe)
		else $error("engine active in local reset");
	a_start_one_cycle: assert property ($fell(transfer_start_n_o) |=> transfer_start_n_o)
		else $error("start strobe too long");
	a_master_code: assert property ($fell(transfer_start_n_o) |-> transaction_code_bus_oe && transaction_code_bus_o == $past(image_tc))
		else $error("wrong master code");
	a_master_size: assert property ($fell(transfer_start_n_o) |-> transfer_size_o == (($past(mst_size) == 2'h3) ? 2'h0 : $past(mst_size)))
		else $error("wrong master size");
	a_code_oe_start: assert property ($rose(transaction_code_bus_oe) |-> !transfer_start_n_o)
		else $error("code driven outside a cycle");
	a_ack_negate: assert property ($fell(slave_ack_n_o) |=> slave_ack_n_o && slave_ack_n_oe ##1 !slave_ack_n_oe)
		else $error("ack not negated before release");
	a_retry_both: assert property (!transfer_error_ack_n_o |-> !slave_ack_n_o)
		else $error("error ack without ack");
	a_slave_code: assert property (slv_start |-> slv_tc == $past(transaction_code_bus_i, 3))
		else $error("slave code not from start edge");
endmodule : pbcs_core_assertions
`default_nettype wire

// File: bench/pbcs_partner.sv
// Processor-side slave that answers this block's master cycles.
// Assumes pull-ups on both answer lines: released, they read high.
`timescale 1ns/1ps
`default_nettype none
module pbcs_partner (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_b,
	// Cycle seen on the bus
	input  wire logic       start_n,
	input  wire logic       start_oe,
	// Answer control
	input  wire logic [3:0] delay,
	input  wire logic       err,
	// Answer lines
	output var  logic       ack_n,
	output var  logic       tea_n
);
	int cnt;
	// --------------------------------
	// Answer after delay cycles
	// --------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cnt   <= -1;
			ack_n <= 1'b1;
			tea_n <= 1'b1;
		end else begin
			ack_n <= 1'b1;
			tea_n <= 1'b1;
			if (!start_n && start_oe)
				cnt <= int'(delay);
			else if (cnt > 0)
				cnt <= cnt - 1;
			else if (cnt == 0) begin
				// Error answer is retry style: both lines low
				ack_n <= 1'b0;
				tea_n <= ~err;
				cnt   <= -1;
			end
		end
	end
endmodule : pbcs_partner
`default_nettype wire

// File: bench/processor_bus_cycle_signals_bench.sv
// Self-checking bench for pbcs_core with a partner for master cycles.
// Assumes clk_en is high but for one freeze; bench drives the slave pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
	error_cnt++; $display("wrong value t=%0t got=%h exp=%h", $time, \
	got, exp); end end
module processor_bus_cycle_signals_bench;
	// --------------------------------
	// Signals
	// --------------------------------
	logic clock = 1'b0, rst_b = 1'b0, clk_en = 1'b1, soft_reset = 1'b0;
	logic local_reset_in_n = 1'b1, pci_reset_n = 1'b1, mst_req = 1'b0;
	logic mst_read = 1'b0, slv_sel = 1'b0, transfer_start_n_i = 1'b1;
	logic rw_i = 1'b0, slv_ready = 1'b0, slv_retry = 1'b0, p_err = 1'b0;
	logic [1:0] mst_size = 2'h0, transfer_size_i = 2'h0;
	logic [1:0] addr_lo = 2'h0, port_width = 2'h0;
	logic [3:0] image_tc = 4'h0, transaction_code_bus_i = 4'h0, p_dly = 4'h0;
	logic local_reset_out_n_oe, mst_done, mst_err, transfer_start_n_o;
	logic transfer_start_n_oe, rw_o, rw_oe, transfer_size_oe;
	logic transaction_code_bus_oe, slave_ack_n_o, slave_ack_n_oe;
	logic transfer_error_ack_n_o, transfer_error_ack_n_oe, slv_start;
	logic slv_read, slv_burst, transfer_ack_n_i, transfer_error_ack_n_i;
	logic [1:0] transfer_size_o;
	logic [3:0] transaction_code_bus_o, slv_tc, slv_lanes;
	int error_cnt = 0, num_checks = 0;

	pbcs_core dut_u (
		.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
		.local_reset_in_n(local_reset_in_n), .pci_reset_n(pci_reset_n),
		.soft_reset(soft_reset), .local_reset_out_n_oe(local_reset_out_n_oe),
		.mst_req(mst_req), .mst_read(mst_read), .mst_size(mst_size),
		.image_tc(image_tc), .mst_done(mst_done), .mst_err(mst_err),
		.transfer_start_n_o(transfer_start_n_o),
		.transfer_start_n_oe(transfer_start_n_oe),
		.rw_o(rw_o), .rw_oe(rw_oe), .transfer_size_o(transfer_size_o),
		.transfer_size_oe(transfer_size_oe),
		.transaction_code_bus_o(transaction_code_bus_o),
		.transaction_code_bus_oe(transaction_code_bus_oe),
		.transfer_ack_n_i(transfer_ack_n_i),
		.transfer_error_ack_n_i(transfer_error_ack_n_i),
		.slv_sel(slv_sel), .transfer_start_n_i(transfer_start_n_i),
		.rw_i(rw_i), .transfer_size_i(transfer_size_i),
		.transaction_code_bus_i(transaction_code_bus_i),
		.addr_lo(addr_lo), .port_width(port_width),
		.slave_ack_n_o(slave_ack_n_o), .slave_ack_n_oe(slave_ack_n_oe),
		.transfer_error_ack_n_o(transfer_error_ack_n_o),
		.transfer_error_ack_n_oe(transfer_error_ack_n_oe),
		.slv_ready(slv_ready), .slv_retry(slv_retry),
		.slv_start(slv_start), .slv_read(slv_read),
		.slv_burst(slv_burst), .slv_tc(slv_tc), .slv_lanes(slv_lanes));
	pbcs_partner part_u (.clock(clock), .rst_b(rst_b),
		.start_n(transfer_start_n_o), .start_oe(transfer_start_n_oe),
		.delay(p_dly), .err(p_err), .ack_n(transfer_ack_n_i),
		.tea_n(transfer_error_ack_n_i));

	initial begin
		forever #4 clock = ~clock;
	end

	// Narrow ports use the high lanes; 16-bit keeps an upper-half access
	function automatic logic [3:0] lanes(logic [1:0] s, a, w);
		logic [3:0] m;
		m = 4'hf;
		if (s == 2'h1) m = 4'h1 << a;
		if (s == 2'h2) m = a[1] ? 4'hc : 4'h3;
		if (w == 2'h1) return a[1] ? (m & 4'hc) : 4'hc;
		if (w == 2'h2) return 4'h8;
		return m;
	endfunction : lanes

	task automatic end_sim();
		if (error_cnt == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim

	task automatic mst_cyc(logic rd, logic [1:0] sz, logic [3:0] tc, d,
		logic e);
		int n;
		@(negedge clock);
		mst_req  = 1'b1;
		mst_read = rd;
		mst_size = sz;
		image_tc = tc;
		p_dly    = d;
		p_err    = e;
		for (n = 0; n < 4 && transfer_start_n_o !== 1'b0; n++)
			@(negedge clock);
		mst_req = 1'b0;
		`CHK(transfer_start_n_o, 1'b0)
		`CHK(transaction_code_bus_o, tc)
		`CHK(rw_o, rd)
		`CHK(transfer_size_o, (sz == 2'h3) ? 2'h0 : sz)
		`CHK(rw_oe, 1'b1)
		`CHK(transaction_code_bus_oe, 1'b1)
		`CHK(transfer_size_oe, 1'b1)
		for (n = 0; n < 40 && mst_done !== 1'b1; n++)
			@(negedge clock);
		`CHK(mst_err, e)
		`CHK(transaction_code_bus_oe, 1'b0)
		`CHK(rw_oe, 1'b0)
		`CHK(transfer_size_oe, 1'b0)
	endtask : mst_cyc

	task automatic slv_cyc(logic rd, logic [1:0] sz, logic [3:0] tc,
		logic [1:0] a, w, logic rt);
		int n;
		@(negedge clock);
		transfer_start_n_i     = 1'b0;
		slv_sel                = 1'b1;
		rw_i                   = rd;
		transfer_size_i        = sz;
		transaction_code_bus_i = tc;
		addr_lo                = a;
		port_width             = w;
		@(negedge clock);
		// Lines no longer qualified flip, so a late sample is caught
		transfer_start_n_i     = 1'b1;
		slv_sel                = 1'b0;
		rw_i                   = ~rd;
		transfer_size_i        = ~sz;
		transaction_code_bus_i = ~tc;
		addr_lo                = ~a;
		for (n = 0; n < 8 && slv_start !== 1'b1; n++)
			@(negedge clock);
		`CHK(slv_tc, tc)
		`CHK(slv_read, rd)
		`CHK(slv_burst, sz == 2'h3)
		`CHK(slv_lanes, lanes(sz, a, w))
		`CHK(rw_oe, 1'b0)
		slv_ready = ~rt;
		slv_retry = rt;
		@(negedge clock);
		slv_ready = 1'b0;
		slv_retry = 1'b0;
		`CHK(slave_ack_n_o, 1'b0)
		`CHK(transfer_error_ack_n_o, ~rt)
		`CHK(transfer_error_ack_n_oe, 1'b1)
		repeat (3) @(negedge clock);
		`CHK(transfer_error_ack_n_oe, 1'b0)
	endtask : slv_cyc

	initial begin
		int i;
		logic [3:0] r;
		void'($urandom(8));
		repeat (3) @(negedge clock);
		rst_b = 1'b1;
		repeat (4) @(negedge clock);
		pci_reset_n = 1'b0;
		repeat (5) @(negedge clock);
		`CHK(local_reset_out_n_oe, 1'b1)
		soft_reset = 1'b1;
		repeat (5) @(negedge clock);
		pci_reset_n = 1'b1;
		repeat (5) @(negedge clock);
		`CHK(local_reset_out_n_oe, 1'b1)
		soft_reset = 1'b0;
		repeat (5) @(negedge clock);
		`CHK(local_reset_out_n_oe, 1'b0)
		// Enable low must hold reset out even as the PCI reset arrives
		clk_en = 1'b0;
		pci_reset_n = 1'b0;
		repeat (5) @(negedge clock);
		`CHK(local_reset_out_n_oe, 1'b0)
		clk_en = 1'b1;
		repeat (5) @(negedge clock);
		`CHK(local_reset_out_n_oe, 1'b1)
		pci_reset_n = 1'b1;
		repeat (5) @(negedge clock);
		local_reset_in_n = 1'b0;
		repeat (5) @(negedge clock);
		`CHK(local_reset_out_n_oe, 1'b0)
		local_reset_in_n = 1'b1;
		repeat (4) @(negedge clock);
		mst_cyc(1'b1, 2'h3, 4'ha, 4'h0, 1'b0);
		mst_cyc(1'b0, 2'h1, 4'h5, 4'hf, 1'b1);
		slv_cyc(1'b1, 2'h3, 4'hc, 2'h0, 2'h0, 1'b1);
		for (i = 0; i < 16; i++) begin
			r = 4'($urandom);
			mst_cyc(r[0], r[2:1], 4'($urandom),
				4'($urandom_range(0, 6)), r[3]);
			slv_cyc(r[1], 2'(i), 4'($urandom), 2'($urandom),
				2'($urandom_range(0, 2)), r[2]);
		end
		end_sim();
	end

	initial begin
		#100000;
		error_cnt++;
		end_sim();
	end
endmodule : processor_bus_cycle_signals_bench

bind pbcs_core pbcs_core_assertions #(.TC_W(TC_W)) chk_u (
	.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
	.local_reset_in_n(local_reset_in_n), .pci_reset_n(pci_reset_n),
	.soft_reset(soft_reset), .local_reset_out_n_oe(local_reset_out_n_oe),
	.mst_size(mst_size), .image_tc(image_tc),
	.transfer_start_n_o(transfer_start_n_o), .rw_oe(rw_oe),
	.transfer_size_o(transfer_size_o),
	.transaction_code_bus_o(transaction_code_bus_o),
	.transaction_code_bus_oe(transaction_code_bus_oe),
	.transaction_code_bus_i(transaction_code_bus_i),
	.slave_ack_n_o(slave_ack_n_o), .slave_ack_n_oe(slave_ack_n_oe),
	.transfer_error_ack_n_o(transfer_error_ack_n_o),
	.slv_start(slv_start), .slv_tc(slv_tc));
`default_nettype wire
